// ==== testbench/serial_port_event_and_burst_ctrl_tb.sv ====
// Self-checking bench for the serial event controller
`include "spb_params.svh"
module serial_port_event_and_burst_ctrl_tb;
  timeunit 1ns / 1ns;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, st = 0, slow = 0;
  logic ack_o, irq_o, te, rf, act, bend, tb;
  logic [31:0] adr_i = 0, dat_i = 0, dat_o, rd, ev = 0;
  logic [3:0] thr = 0;
  int miscompares = 0, num_checks = 0, seed = 83948, n, k, len, pm;
  int eb[5] = '{11, 8, 3, 2, 0};
  spb_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tx_underrun_i(ev[0]), .tx_shift_busy_i(ev[1]),
    .tx_fifo_free_i(thr), .tx_burst_start_i(st), .tx_bit_i(tb), .rx_overrun_i(ev[2]), .rx_burst_end_i(ev[3]),
    .rx_fifo_valid_i(thr), .rx_shift_busy_i(ev[4]), .irq_o(irq_o), .tx_fifo_empty_o(te), .rx_fifo_full_o(rf),
    .tx_burst_active_o(act), .tx_burst_end_o(bend));
  spb_peer u_peer (.clk_i(clk_i), .rst_i(rst_i), .active_i(act), .slow_i(slow), .bit_o(tb));
  initial forever #20 clk_i = ~clk_i;
  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) $display("wrong value at %0t: %h, expected %h", $time, s, e);
    miscompares += (s !== e);
  endtask
  task automatic tmo();
    miscompares += (k >= 50);
    if (k >= 50) results();
  endtask
  task automatic wb(input logic w, input logic [31:0] a, d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    k = 0;
    do @(posedge clk_i); while (ack_o !== 1 && ++k < 50);
    tmo();
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    wb(0, `SPB_IDX_MASK, 0);
    chk(rd, 32'h0F0F);
    wb(0, 32'h0B000910, 0);
    chk(rd, 0);
    wb(1, `SPB_IDX_MASK, 32'hFFFF);
    wb(0, `SPB_IDX_MASK, 0);
    chk(rd, 32'h0F0F);
    wb(0, `SPB_IDX_PEND, 0);
    chk(rd, 0);
    wb(0, `SPB_IDX_TXLEN, 0);
    chk(rd, 0);
    st <= 1;
    @(posedge clk_i);
    st <= 0;
    repeat (2) @(posedge clk_i);
    chk(act, 0);
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      wb(1, `SPB_IDX_MASK, i[0] ? 32'h0F0F : 0);
      ev[i] <= 1;
      @(posedge clk_i);
      ev[i] <= 0;
      pm = 1 << eb[i];
      wb(1, `SPB_IDX_PEND, 0);
      wb(0, `SPB_IDX_PEND, 0);
      chk(rd, pm);
      chk(irq_o, !i[0]);
      wb(1, `SPB_IDX_PEND, pm);
    end
    for (int c = 0; c < 3; c++) begin
      wb(1, `SPB_IDX_CFG, c << 14 | c << 6);
      for (int j = 0; j < 2; j++) begin
        thr <= 4'((1 << c) - 1 + j);
        repeat (2) @(posedge clk_i);
        chk(te, j);
        chk(rf, j);
      end
    end
    wb(0, `SPB_IDX_CFG, 0);
    chk(rd, 32'h8284);
    wb(0, `SPB_IDX_PEND, 0);
    chk(rd, 32'h0202);
    chk(irq_o, 1);
    wb(1, `SPB_IDX_PEND, 32'hFFFF);
    $display("event test done");
    for (int t = 0; t < 4; t++) begin
      len = (xs() & 7) + 1;
      slow <= t[0];
      wb(1, `SPB_IDX_TXLEN, len);
      st <= 1;
      @(posedge clk_i);
      st <= 0;
      n = 0;
      for (k = 0; k < 50 && bend !== 1; k++) begin
        @(posedge clk_i);
        n += tb && act;
      end
      tmo();
      chk(n, len);
      wb(0, `SPB_IDX_PEND, 0);
      chk(rd, 32'h0400);
      wb(1, `SPB_IDX_PEND, 32'h0400);
    end
    $display("burst test done");
    results();
  end
endmodule

// ==== testbench/spb_checker.sv ====
// Port assertions for the serial event controller
module spb_checker (
  input logic clk_i,
  input logic rst_i,
  input logic cyc_i,
  input logic stb_i,
  input logic tx_bit_i,
  input logic [31:0] dat_o,
  input logic ack_o,
  input logic tx_burst_active_o,
  input logic tx_burst_end_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_src; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_src: assert property (p_src) else $error("stray ack");
  property p_one; ack_o |=> !ack_o; endproperty
  a_one: assert property (p_one) else $error("long ack");
  property p_dat; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("stray data");
  property p_end; tx_burst_end_o |=> !tx_burst_end_o; endproperty
  a_end: assert property (p_end) else $error("long end");
  property p_bit; tx_burst_end_o |-> $past(tx_bit_i); endproperty
  a_bit: assert property (p_bit) else $error("end without bit");
  property p_off; tx_burst_end_o |-> $past(tx_burst_active_o) && !tx_burst_active_o; endproperty
  a_off: assert property (p_off) else $error("end outside burst");
  property p_fall; $fell(tx_burst_active_o) && !$past(rst_i) |-> tx_burst_end_o; endproperty
  a_fall: assert property (p_fall) else $error("burst cut");
endmodule
bind spb_ctrl spb_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .tx_bit_i(tx_bit_i),
  .dat_o(dat_o), .ack_o(ack_o), .tx_burst_active_o(tx_burst_active_o), .tx_burst_end_o(tx_burst_end_o));

// ==== testbench/spb_peer.sv ====
// Far-side serial peer strobing one bit per transfer
module spb_peer (
  input logic clk_i,
  input logic rst_i,
  input logic active_i,
  input logic slow_i,
  output logic bit_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog_q;
  always_ff @(posedge clk_i) tog_q <= rst_i ? 1'b0 : ~tog_q;
  always_ff @(posedge clk_i) bit_o <= !rst_i && active_i && (!slow_i || tog_q);
endmodule

// ==== verilog/spb_ctrl.sv ====
// Serial port event flags, masks, interrupt and transmit burst counter
//
// Added by the designer: the Wishbone interface to the registers.
`include "spb_params.svh"

// Contract
// - Transmit mask bits 11..8, one blocks
// - Receive mask bits 3..0, one blocks
// - Pending bit 11 on transmit underrun
// - Pending bit 10 on transmit burst end
// - Pending bit 9 on transmit empty threshold
// - Pending bit 8 on transmit shifter busy
// - Pending bit 3 on receive overrun
// - Pending bit 2 on receive burst end
// - Pending bit 1 on receive full threshold
// - Pending bit 0 on receive shifter busy
// - Writing one clears pending, zero keeps
// - Reserved mask and pending bits read zero
// - Burst sends exactly programmed bit count
// - Transmit empty when free reaches threshold
// - Receive full when valid reaches threshold
module spb_ctrl #(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Transmit side events
  input wire logic tx_underrun_i,
  input wire logic tx_shift_busy_i,
  input wire logic [CNT_W-1:0] tx_fifo_free_i,
  input wire logic tx_burst_start_i,
  input wire logic tx_bit_i,
  // Receive side events
  input wire logic rx_overrun_i,
  input wire logic rx_burst_end_i,
  input wire logic [CNT_W-1:0] rx_fifo_valid_i,
  input wire logic rx_shift_busy_i,
  // Status outputs
  output logic irq_o,
  output logic tx_fifo_empty_o,
  output logic rx_fifo_full_o,
  output logic tx_burst_active_o,
  output logic tx_burst_end_o
);

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0] sel
  );
    logic [15:0] r;
    r = old_v;
    if (sel[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (sel[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  // Threshold code to word count; reserved code acts as four words
  function automatic logic [CNT_W:0] thr_words(input logic [1:0] code);
    logic [CNT_W:0] w;
    w = (CNT_W+1)'(4);
    case (code)
      `SPB_THR_1: w = (CNT_W+1)'(1);
      `SPB_THR_2: w = (CNT_W+1)'(2);
      `SPB_THR_4: w = (CNT_W+1)'(4);
      default: w = (CNT_W+1)'(4);
    endcase
    return w;
  endfunction

  // Registers decode on the full byte address; unmapped addresses still answer
  function automatic logic adr_hit(
    input logic [31:0] adr,
    input logic [31:0] idx
  );
    return adr == idx;
  endfunction

  // Bus state
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [15:0] pend_q;
  logic [15:0] pend_d;
  logic [15:0] txlen_q;
  logic [15:0] txlen_d;
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic irq_q;
  logic irq_d;

  // Event state
  logic txe_q;
  logic txe_d;
  logic rxf_q;
  logic rxf_d;
  logic txbusy_prev_q;
  logic txbusy_prev_d;
  logic rxbusy_prev_q;
  logic rxbusy_prev_d;

  // Burst state
  spb_pkg::spb_burst_state_t st_q;
  spb_pkg::spb_burst_state_t st_d;
  logic [15:0] bitcnt_q;
  logic [15:0] bitcnt_d;

  logic req;
  logic wr;
  logic rd;
  logic [15:0] wdat;
  logic [15:0] evt;
  logic [15:0] clr;
  logic hit_mask;
  logic hit_pend;
  logic hit_txlen;
  logic hit_cfg;

  assign req = cyc_i & stb_i & ~ack_q;
  assign wr = req & we_i;
  assign rd = req & ~we_i;
  assign wdat = dat_i[15:0];

  // Address decode shared by the write and read paths
  always_comb begin
    hit_mask = adr_hit(adr_i, `SPB_IDX_MASK);
    hit_pend = adr_hit(adr_i, `SPB_IDX_PEND);
    hit_txlen = adr_hit(adr_i, `SPB_IDX_TXLEN);
    hit_cfg = adr_hit(adr_i, `SPB_IDX_CFG);
  end

  // Threshold comparisons on the live FIFO counts
  always_comb begin
    txe_d = {1'b0, tx_fifo_free_i} >= thr_words(cfg_q[`SPB_CFG_TXTHR_LSB +: 2]);
    rxf_d = {1'b0, rx_fifo_valid_i} >= thr_words(cfg_q[`SPB_CFG_RXTHR_LSB +: 2]);
    // Busy levels are kept one cycle so that only their rise raises a flag
    txbusy_prev_d = tx_shift_busy_i;
    rxbusy_prev_d = rx_shift_busy_i;
  end

  // Event sources; level sources raise a flag on their rising edge only
  always_comb begin
    evt = 16'h0000;
    evt[`SPB_B_TX_UNDERRUN] = tx_underrun_i;
    evt[`SPB_B_TX_BURST_END] = st_q == spb_pkg::SPB_DONE;
    evt[`SPB_B_TX_FIFO_EMPTY] = txe_d & ~txe_q;
    evt[`SPB_B_TX_SHIFT_BUSY] = tx_shift_busy_i & ~txbusy_prev_q;
    evt[`SPB_B_RX_OVERRUN] = rx_overrun_i;
    evt[`SPB_B_RX_BURST_END] = rx_burst_end_i;
    evt[`SPB_B_RX_FIFO_FULL] = rxf_d & ~rxf_q;
    evt[`SPB_B_RX_SHIFT_BUSY] = rx_shift_busy_i & ~rxbusy_prev_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txe_q <= 1'b0;
      rxf_q <= 1'b0;
      txbusy_prev_q <= 1'b0;
      rxbusy_prev_q <= 1'b0;
    end else begin
      txe_q <= txe_d;
      rxf_q <= rxf_d;
      txbusy_prev_q <= txbusy_prev_d;
      rxbusy_prev_q <= rxbusy_prev_d;
    end
  end

  // Register file next state
  always_comb begin
    mask_d = mask_q;
    txlen_d = txlen_q;
    cfg_d = cfg_q;
    clr = 16'h0000;
    if (wr && hit_mask) begin
      mask_d = lane_merge(mask_q, wdat, sel_i[1:0]) & `SPB_EVT_BITS;
    end
    if (wr && hit_pend) begin
      clr = lane_merge(16'h0000, wdat, sel_i[1:0]);
    end
    if (wr && hit_txlen) begin
      txlen_d = lane_merge(txlen_q, wdat, sel_i[1:0]);
    end
    if (wr && hit_cfg) begin
      cfg_d = lane_merge(cfg_q, wdat, sel_i[1:0]) & `SPB_CFG_WR_BITS;
    end
    // A new event wins over a clear in the same cycle, so no event is lost to a late clear
    pend_d = ((pend_q & ~clr) | evt) & `SPB_EVT_BITS;
    // Interrupt follows the registered flags, one cycle behind them
    irq_d = |(pend_q & ~mask_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= `SPB_MASK_RST;
      pend_q <= `SPB_PEND_RST;
      txlen_q <= `SPB_TXLEN_RST;
      cfg_q <= `SPB_CFG_RST;
      irq_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      pend_q <= pend_d;
      txlen_q <= txlen_d;
      cfg_q <= cfg_d;
      irq_q <= irq_d;
    end
  end

  // Bus answer; read data stands only with ack and is zero otherwise
  always_comb begin
    ack_d = req;
    rdat_d = 32'h00000000;
    if (rd) begin
      if (hit_mask) begin
        rdat_d = {16'h0000, mask_q};
      end else if (hit_pend) begin
        rdat_d = {16'h0000, pend_q};
      end else if (hit_txlen) begin
        rdat_d = {16'h0000, txlen_q};
      end else if (hit_cfg) begin
        rdat_d[15:0] = cfg_q;
        rdat_d[`SPB_CFG_ST_TXEMPTY] = txe_q;
        rdat_d[`SPB_CFG_ST_TXBUSY] = st_q == spb_pkg::SPB_SHIFT;
        rdat_d[`SPB_CFG_ST_RXFULL] = rxf_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Transmit burst counter; a zero length never starts, so the shifter idles
  // A length written mid-burst acts at once, since the end test is a compare
  always_comb begin
    st_d = st_q;
    bitcnt_d = bitcnt_q;
    case (st_q)
      spb_pkg::SPB_IDLE: begin
        if (tx_burst_start_i && txlen_q != `SPB_LEN_RESERVED) begin
          st_d = spb_pkg::SPB_SHIFT;
          bitcnt_d = 16'h0000;
        end
      end
      spb_pkg::SPB_SHIFT: begin
        if (tx_bit_i) begin
          if (bitcnt_q + 16'h0001 >= txlen_q) begin
            st_d = spb_pkg::SPB_DONE;
          end
          bitcnt_d = bitcnt_q + 16'h0001;
        end
      end
      spb_pkg::SPB_DONE: begin
        st_d = spb_pkg::SPB_IDLE;
      end
      default: begin
        st_d = spb_pkg::SPB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= spb_pkg::SPB_IDLE;
      bitcnt_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      bitcnt_q <= bitcnt_d;
    end
  end

  // One-hot state bits feed the outputs directly
  assign dat_o = rdat_q;
  assign ack_o = ack_q;
  assign irq_o = irq_q;
  assign tx_fifo_empty_o = txe_q;
  assign rx_fifo_full_o = rxf_q;
  assign tx_burst_active_o = st_q[1];
  assign tx_burst_end_o = st_q[2];

endmodule

// ==== verilog/spb_params.svh ====
// Register indices, field positions, reset values and bus constants
`ifndef SPB_PARAMS_SVH
`define SPB_PARAMS_SVH
// Register byte addresses on the register bus
`define SPB_IDX_MASK 32'h0B000908
`define SPB_IDX_PEND 32'h0B00090A
`define SPB_IDX_TXLEN 32'h0B00090C
`define SPB_IDX_CFG 32'h0B000912
// Event bit positions, shared by mask and pending
`define SPB_B_TX_UNDERRUN 11
`define SPB_B_TX_BURST_END 10
`define SPB_B_TX_FIFO_EMPTY 9
`define SPB_B_TX_SHIFT_BUSY 8
`define SPB_B_RX_OVERRUN 3
`define SPB_B_RX_BURST_END 2
`define SPB_B_RX_FIFO_FULL 1
`define SPB_B_RX_SHIFT_BUSY 0
`define SPB_EVT_BITS 16'h0F0F
`define SPB_MASK_RST 16'h0F0F
`define SPB_PEND_RST 16'h0000
`define SPB_TXLEN_RST 16'h0000
// Configuration register fields
`define SPB_CFG_TXTHR_LSB 14
`define SPB_CFG_RXTHR_LSB 6
`define SPB_CFG_WR_BITS 16'hC0C0
`define SPB_CFG_RST 16'h0000
`define SPB_CFG_ST_TXEMPTY 9
`define SPB_CFG_ST_TXBUSY 8
`define SPB_CFG_ST_RXFULL 2
// Threshold codes
`define SPB_THR_1 2'h0
`define SPB_THR_2 2'h1
`define SPB_THR_4 2'h2
`define SPB_LEN_RESERVED 16'h0000
`endif

// ==== verilog/spb_pkg.sv ====
// Types for the serial event and burst controller
package spb_pkg;
  typedef enum logic [2:0] {
    SPB_IDLE = 3'h1,
    SPB_SHIFT = 3'h2,
    SPB_DONE = 3'h4
  } spb_burst_state_t;
endpackage
